/* srq_pkg.sv */
// Constants, types and reset values of the setting readout and inquiry reply block.
// Assumes a 100 MHz hclk and an AHB-Lite bus with a single slave.
//
// Contract
// (RULE1) Capture the 16-bit setting word once after reset, keep it until next reset.
// (RULE2) Select pin low at reset exit: take the word from the sixteen switch pins.
// (RULE3) Switch pins read low mean ON and are recorded as logic 1.
// (RULE4) Select pin high or open: read the word serially from the companion chip.
// (RULE5) Serial transfer is a plain shift: load strobe, then sixteen clocked bits.
// (RULE6) Output-station byte bits 7:6 choose cyclic, single, period or moving average.
// (RULE7) Low six bits of each setting byte form a binary station address.
// (RULE8) Station byte bits 7:6 give 12, 6 or 3 Mbps; both ON is invalid.
// (RULE9) Output-station address only checks the sender of setting-change mail.
// (RULE10) An eight-byte inquiry mail matching the fixed pattern gets the basic reply.
// (RULE11) Inquiries are answered from any sending node, not only the output station.
// (RULE12) Reply bytes 6 and 7 hold the version as two ASCII digits, tens first.
// (RULE13) Reply bytes 0x0A/0x0B hold the setting bytes; bytes 0x0E/0x0F are zero.
// (RULE14) Reply bytes 0x10 to 0x17 hold interval, function, count, trigger fields, zero.
// (RULE15) Status one bits 7:6 show 1 where a method switch was ON at reset exit.
// (RULE16) Status one bit 5 shows 1 when the mode select pin was low at reset exit.
// (RULE17) Status one bit 4 follows the converter link error state.
// (RULE18) Status one bit 3 is the trigger source select, default 1; bit 2 is 0.
// (RULE19) Status one bit 1 is the peak discard select, default 1.
// (RULE20) Status one bit 0 shows 1 when the polarity pin was low at reset exit.
// (RULE21) Reply byte 8 holds the message type code, 0x4D for this reply.
package srq_pkg;
   localparam logic [7:0] REG_SETTING = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INTERVAL = 8'h08;
   localparam logic [7:0] REG_FUNCTION = 8'h0C;
   localparam logic [7:0] REG_COUNT = 8'h10;
   localparam logic [7:0] REG_TRIG_ADDR = 8'h14;
   localparam logic [7:0] REG_TRIG_DATA = 8'h18;
   localparam logic [15:0] INTERVAL_RESET = 16'h000A;
   localparam logic [7:0] FUNCTION_RESET = 8'h03;
   localparam logic [7:0] COUNT_RESET = 8'h08;
   localparam logic [15:0] TRIG_ADDR_RESET = 16'h0000;
   localparam logic [7:0] TRIG_DATA_RESET = 8'hFF;
   localparam int FS_PEAK_BIT = 0;
   localparam int FS_TRIG_BIT = 1;
   localparam int SET_METHOD_LSB = 14;
   localparam int SET_RATE_LSB = 6;
   localparam int PIN_SELECT = 16;
   localparam int PIN_MODE = 17;
   localparam int PIN_POLARITY = 18;
   localparam int PIN_SERIAL = 19;
   localparam int PIN_LINK_ERR = 20;
   localparam int PIN_COUNT = 21;
   localparam logic [63:0] INQUIRY_PATTERN = 64'h0D3F2074656E5543;
   localparam logic [7:0] TYPE_MASTER = 8'h4D;
   localparam logic [7:0] TYPE_WRITE = 8'h57;
   localparam logic [7:0] TYPE_ACK = 8'h41;
   localparam logic [7:0] TYPE_NAK = 8'h4E;
   localparam logic [7:0] TYPE_READ = 8'h52;
   localparam logic [7:0] CODE_FROM_MASTER = 8'h00;
   localparam logic [4:0] REPLY_LAST = 5'h17;
   localparam logic [3:0] SETTLE_CYCLES = 4'h6;
   localparam logic [4:0] SERIAL_BITS = 5'h10;
   localparam int SERIAL_HALF_NS = 500;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [6:0] SERIAL_HALF_CYCLES = 7'((SERIAL_HALF_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS);
   typedef enum logic [2:0] {
      PH_SETTLE = 3'b000,
      PH_PICK = 3'b001,
      PH_LOAD = 3'b010,
      PH_SHIFT = 3'b011,
      PH_DONE = 3'b100
   } srq_phase_t;
   typedef enum logic [1:0] {
      METHOD_CYCLIC = 2'b00,
      METHOD_SINGLE = 2'b01,
      METHOD_PERIOD = 2'b10,
      METHOD_MOVING = 2'b11
   } srq_method_t;
   typedef enum logic [1:0] {
      RATE_12M = 2'b00,
      RATE_6M = 2'b01,
      RATE_3M = 2'b10,
      RATE_BAD = 2'b11
   } srq_rate_t;
endpackage

/* srq_top.sv */
// Setting readout after reset, setting decode, register file and inquiry mail reply.
// Assumes switch and select pins are asynchronous, mail bytes come from logic on hclk.
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module srq_top
   import srq_pkg::*;
#(
   // Product name bytes, byte 0 in bits 7:0; the value is arbitrary.
   parameter logic [39:0] PRODUCT_ID = 40'h5A30305A58,
   parameter logic [7:0] VERSION_TENS = 8'h30,
   parameter logic [7:0] VERSION_ONES = 8'h31
)
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Setting pins, active low except converter_link_error, which is active high.
   input wire logic [7:0] station_switch_input_n,
   input wire logic [7:0] output_station_switch_input_n,
   input wire logic setting_source_select_n,
   input wire logic setting_mode_select_n,
   input wire logic analog_polarity_select_n,
   input wire logic converter_link_error,
   // Companion switch reader.
   output logic reader_clock,
   output logic reader_load,
   input wire logic reader_data,
   // Decoded configuration.
   output logic config_valid,
   output logic [1:0] sampling_method,
   output logic [1:0] link_rate,
   output logic link_rate_invalid,
   output logic [5:0] station_address,
   output logic [5:0] output_station_address,
   // Received mail.
   input wire logic rx_valid,
   input wire logic rx_first,
   input wire logic rx_last,
   input wire logic [7:0] rx_byte,
   input wire logic [5:0] rx_sender,
   // Reply mail.
   output logic tx_valid,
   output logic tx_first,
   output logic tx_last,
   output logic [7:0] tx_byte,
   output logic [5:0] tx_dest,
   input wire logic tx_ready,
   // Setting-change mail sender check.
   output logic change_mail_seen,
   output logic change_sender_ok
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [PIN_COUNT-1:0] s1;
      logic [PIN_COUNT-1:0] s2;
      logic [PIN_COUNT-1:0] s3;
      logic [PIN_COUNT-1:0] filt;
      logic [3:0] settle;
      srq_phase_t phase;
      logic [6:0] div;
      logic [4:0] bits;
      logic sclk;
      logic sload;
      logic [15:0] word;
      logic valid;
      logic rate_bad;
      logic serial_src;
      logic mode_low;
      logic pol_low;
      logic ready;
      logic resp;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [31:0] rdata;
      logic [15:0] interval;
      logic [7:0] func;
      logic [7:0] count;
      logic [15:0] taddr;
      logic [7:0] tdata;
      logic [3:0] rxcnt;
      logic rxmatch;
      logic txv;
      logic txf;
      logic txl;
      logic [4:0] txidx;
      logic [7:0] txb;
      logic [5:0] txdest;
      logic chg_seen;
      logic chg_ok;
   } srq_state_t;

   srq_state_t r_reg;
   srq_state_t r_next;
   logic [PIN_COUNT-1:0] pins;
   logic addr_phase;
   logic [3:0] rx_pos;
   logic rx_hit;
   logic inquiry_done;
   logic tx_take;

   assign pins = {converter_link_error, reader_data, analog_polarity_select_n,
      setting_mode_select_n, setting_source_select_n, output_station_switch_input_n,
      station_switch_input_n};

   ////////////////////////////////////////////////////////////////////////////////////////
   // Functions.

   function automatic logic [7:0] status_one(input srq_state_t s);
      status_one = {s.word[15], s.word[14], s.mode_low, s.filt[PIN_LINK_ERR],
         s.func[FS_TRIG_BIT], 1'b0, s.func[FS_PEAK_BIT], s.pol_low}; // see (RULE15) (RULE16)
      // see (RULE17) (RULE18) (RULE19) (RULE20)
   endfunction

   function automatic logic [7:0] reply_byte(input logic [4:0] idx, input srq_state_t s);
      case (idx)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04:
            reply_byte = PRODUCT_ID[8*idx +: 8];
         5'h05: reply_byte = 8'h20;
         5'h06: reply_byte = VERSION_TENS; // see (RULE12)
         5'h07: reply_byte = VERSION_ONES;
         5'h08: reply_byte = TYPE_MASTER; // see (RULE21)
         5'h09: reply_byte = CODE_FROM_MASTER;
         5'h0A: reply_byte = s.word[7:0]; // see (RULE13)
         5'h0B: reply_byte = s.word[15:8];
         5'h0C: reply_byte = status_one(s);
         5'h0D: reply_byte = {1'b0, ~s.serial_src, 6'h00};
         5'h10: reply_byte = s.interval[7:0]; // see (RULE14)
         5'h11: reply_byte = s.interval[15:8];
         5'h12: reply_byte = s.func;
         5'h13: reply_byte = s.count;
         5'h14: reply_byte = s.taddr[7:0];
         5'h15: reply_byte = s.taddr[15:8];
         5'h16: reply_byte = s.tdata;
         default: reply_byte = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // Next state.

   assign addr_phase = hsel && htrans[1] && hready;
   assign rx_pos = rx_first ? 4'h0 : r_reg.rxcnt;
   assign rx_hit = (rx_first || r_reg.rxmatch) && !rx_pos[3]
      && (rx_byte == INQUIRY_PATTERN[8*rx_pos[2:0] +: 8]);
   assign inquiry_done = rx_valid && rx_last && rx_hit && (rx_pos == 4'h7); // see (RULE10)
   assign tx_take = r_reg.txv && tx_ready;

   always_comb
   begin
      r_next = r_reg;
      r_next.s1 = pins;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (r_reg.s2[i] == r_reg.s3[i])
         begin
            r_next.filt[i] = r_reg.s3[i];
         end
      end
      r_next.chg_seen = 1'b0;
      if (r_reg.div == 7'h00)
      begin
         r_next.div = SERIAL_HALF_CYCLES - 7'h01;
      end
      else
      begin
         r_next.div = r_reg.div - 7'h01;
      end
      case (r_reg.phase)
         PH_SETTLE:
         begin
            r_next.settle = r_reg.settle + 4'h1;
            if (r_reg.settle == SETTLE_CYCLES)
            begin
               r_next.phase = PH_PICK;
            end
         end
         PH_PICK:
         begin
            r_next.mode_low = ~r_reg.filt[PIN_MODE];
            r_next.pol_low = ~r_reg.filt[PIN_POLARITY];
            r_next.serial_src = r_reg.filt[PIN_SELECT];
            if (!r_reg.filt[PIN_SELECT])
            begin
               r_next.word = ~r_reg.filt[15:0]; // see (RULE2) (RULE3)
               r_next.valid = 1'b1; // see (RULE1)
               r_next.phase = PH_DONE;
            end
            else
            begin
               r_next.phase = PH_LOAD; // see (RULE4)
               r_next.div = SERIAL_HALF_CYCLES - 7'h01;
               r_next.sload = 1'b1;
            end
         end
         PH_LOAD:
         begin
            if (r_reg.div == 7'h00)
            begin
               r_next.sload = 1'b0; // see (RULE5)
               r_next.phase = PH_SHIFT;
            end
         end
         PH_SHIFT:
         begin
            if (r_reg.div == 7'h00)
            begin
               if (!r_reg.sclk)
               begin
                  r_next.sclk = 1'b1;
                  r_next.word = {r_reg.word[14:0], ~r_reg.filt[PIN_SERIAL]}; // see (RULE5)
                  r_next.bits = r_reg.bits + 5'h01;
               end
               else
               begin
                  r_next.sclk = 1'b0;
                  if (r_reg.bits == SERIAL_BITS)
                  begin
                     r_next.valid = 1'b1; // see (RULE1)
                     r_next.phase = PH_DONE;
                  end
               end
            end
         end
         PH_DONE:
         begin
            r_next.phase = PH_DONE;
         end
         default:
         begin
            r_next.phase = PH_SETTLE;
         end
      endcase
      r_next.rate_bad = r_next.valid && (r_next.word[SET_RATE_LSB +: 2] == RATE_BAD);
      r_next.dph_wr = addr_phase && hwrite;
      r_next.dph_addr = haddr[7:0];
      if (r_reg.dph_wr)
      begin
         case (r_reg.dph_addr)
            REG_INTERVAL: r_next.interval = hwdata[15:0];
            REG_FUNCTION: r_next.func = hwdata[7:0];
            REG_COUNT: r_next.count = hwdata[7:0];
            REG_TRIG_ADDR: r_next.taddr = hwdata[15:0];
            REG_TRIG_DATA: r_next.tdata = hwdata[7:0];
            default: r_next.interval = r_reg.interval;
         endcase
      end
      if (addr_phase && !hwrite)
      begin
         case (haddr[7:0])
            REG_SETTING: r_next.rdata = {10'h000, r_reg.word[15:14], r_reg.word[7:6],
               r_reg.serial_src, r_reg.valid, r_reg.word};
            REG_STATUS: r_next.rdata = {16'h0000, 1'b0, ~r_reg.serial_src, 6'h00,
               status_one(r_reg)};
            REG_INTERVAL: r_next.rdata = {16'h0000, r_reg.interval};
            REG_FUNCTION: r_next.rdata = {24'h000000, r_reg.func};
            REG_COUNT: r_next.rdata = {24'h000000, r_reg.count};
            REG_TRIG_ADDR: r_next.rdata = {16'h0000, r_reg.taddr};
            REG_TRIG_DATA: r_next.rdata = {24'h000000, r_reg.tdata};
            default: r_next.rdata = 32'h00000000;
         endcase
      end
      if (rx_valid)
      begin
         r_next.rxcnt = rx_pos[3] ? rx_pos : rx_pos + 4'h1;
         r_next.rxmatch = rx_hit;
         if (rx_last && !inquiry_done)
         begin
            r_next.chg_seen = 1'b1;
            r_next.chg_ok = (rx_sender == r_reg.word[13:8]); // see (RULE9)
         end
      end
      if (tx_take)
      begin
         r_next.txf = 1'b0;
         if (r_reg.txidx == REPLY_LAST)
         begin
            r_next.txv = 1'b0;
            r_next.txl = 1'b0;
         end
         else
         begin
            r_next.txidx = r_reg.txidx + 5'h01;
            r_next.txb = reply_byte(r_reg.txidx + 5'h01, r_reg);
            r_next.txl = (r_reg.txidx + 5'h01 == REPLY_LAST);
         end
      end
      if (inquiry_done && r_reg.valid && !r_reg.txv)
      begin
         r_next.txv = 1'b1;
         r_next.txf = 1'b1;
         r_next.txl = 1'b0;
         r_next.txidx = 5'h00;
         r_next.txb = reply_byte(5'h00, r_reg);
         r_next.txdest = rx_sender; // see (RULE11)
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r_reg <= '0;
         r_reg.phase <= PH_SETTLE;
         r_reg.ready <= 1'b1;
         r_reg.interval <= INTERVAL_RESET;
         r_reg.func <= FUNCTION_RESET;
         r_reg.count <= COUNT_RESET;
         r_reg.taddr <= TRIG_ADDR_RESET;
         r_reg.tdata <= TRIG_DATA_RESET;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign hreadyout = r_reg.ready;
   assign hresp = r_reg.resp;
   assign hrdata = r_reg.rdata;
   assign reader_clock = r_reg.sclk;
   assign reader_load = r_reg.sload;
   assign config_valid = r_reg.valid;
   assign sampling_method = r_reg.word[SET_METHOD_LSB +: 2]; // see (RULE6)
   assign link_rate = r_reg.word[SET_RATE_LSB +: 2]; // see (RULE8)
   assign link_rate_invalid = r_reg.rate_bad; // see (RULE8)
   assign station_address = r_reg.word[5:0]; // see (RULE7)
   assign output_station_address = r_reg.word[13:8];
   assign tx_valid = r_reg.txv;
   assign tx_first = r_reg.txf;
   assign tx_last = r_reg.txl;
   assign tx_byte = r_reg.txb;
   assign tx_dest = r_reg.txdest;
   assign change_mail_seen = r_reg.chg_seen;
   assign change_sender_ok = r_reg.chg_ok;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   logic [4:0] clk_rises;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_rises <= 5'h00;
      end
      else if (!r_reg.sclk && r_next.sclk)
      begin
         clk_rises <= clk_rises + 5'h01;
      end
   end

   sequence s_inquiry;
      inquiry_done && r_reg.valid && !r_reg.txv;
   endsequence

   sequence s_reply_start;
      tx_valid && tx_first && (tx_byte == PRODUCT_ID[7:0]);
   endsequence

   a_capture_once: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(config_valid) |-> config_valid && $stable(r_reg.word)) // see (RULE1)
      else $error("setting word changed after capture");
   a_parallel_word: assert property (@(posedge hclk) disable iff (!hresetn)
      (r_reg.phase == PH_PICK && !r_reg.filt[PIN_SELECT])
      |=> config_valid && (r_reg.word == ~$past(r_reg.filt[15:0]))) // see (RULE2) (RULE3)
      else $error("parallel capture wrong");
   a_serial_pick: assert property (@(posedge hclk) disable iff (!hresetn)
      (r_reg.phase == PH_PICK && r_reg.filt[PIN_SELECT])
      |=> reader_load && !config_valid ##[1:60] !reader_load) // see (RULE4)
      else $error("serial readout not started");
   a_serial_bits: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(config_valid) && r_reg.serial_src |-> clk_rises == SERIAL_BITS) // see (RULE5)
      else $error("serial bit count wrong");
   a_method_decode: assert property (@(posedge hclk) disable iff (!hresetn)
      config_valid |-> sampling_method == r_reg.word[15:14]
      && station_address == r_reg.word[5:0]) // see (RULE6) (RULE7)
      else $error("method or address decode wrong");
   a_rate_invalid: assert property (@(posedge hclk) disable iff (!hresetn)
      config_valid |-> link_rate_invalid == (r_reg.word[7:6] == 2'b11)) // see (RULE8)
      else $error("rate validity wrong");
   a_inquiry_reply: assert property (@(posedge hclk) disable iff (!hresetn)
      s_inquiry |=> s_reply_start and (tx_dest == $past(rx_sender))) // see (RULE10) (RULE11)
      else $error("inquiry not answered");
   a_reply_fields: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_valid && r_reg.txidx == 5'h0A |-> tx_byte == r_reg.word[7:0]) // see (RULE13)
      else $error("station byte wrong in reply");
   a_status_bits: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_valid && r_reg.txidx == 5'h0C |-> !tx_byte[2] && tx_byte[5] == r_reg.mode_low
      && tx_byte[7:6] == r_reg.word[15:14]) // see (RULE15) (RULE16) (RULE18)
      else $error("status byte wrong");
   a_type_code: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_valid && r_reg.txidx == 5'h08 |-> tx_byte == 8'h4D) // see (RULE21)
      else $error("message type wrong");
   a_reply_length: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_valid && tx_last && tx_ready |=> !tx_valid && $past(r_reg.txidx) == 5'h17)
      else $error("reply length wrong");

endmodule

/* srq_reader_model.sv */
// Behavioural switch reader on the far side of the serial setting link.
// Assumes a load strobe, then clock pulses from the block, each bit taken on a rising edge.
`timescale 1ns/100ps
module srq_reader_model (
   // Link from the block.
   input wire logic reader_clock,
   input wire logic reader_load,
   // Switch levels, low means ON.
   input wire logic [15:0] switch_pins_n,
   // Serial bit to the block.
   output logic reader_data
);
   logic [15:0] shift_reg = 16'h0000;
   int rises = 16;
   int idx = 16;
   ////////////////////////////////////////
   // The load strobe latches the switches and restarts the frame.
   always @(posedge reader_load)
   begin
      shift_reg = switch_pins_n;
      rises = 0;
      idx = 0;
   end
   // Bits move on the falling edge, away from the sampling edge.
   always @(posedge reader_clock)
      rises = rises + 1;
   always @(negedge reader_clock)
      idx = rises;
   // Pin levels go out MSB first; outside a frame the line shows no stale bit.
   assign reader_data = (idx < 16) ? shift_reg[15 - idx] : ~shift_reg[0];
endmodule

/* tb.sv */
// Self-checking bench for the setting readout and inquiry reply block.
// Assumes the serial reader model and a single AHB-Lite slave on hclk.
`timescale 1ns/100ps
module tb;
   import srq_pkg::*;
   // Product bytes handed to the design; the value is arbitrary.
   localparam logic [39:0] PID = 40'h5A30305A58;
   logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, method, rate;
   logic [2:0] hsize = 3'h0;
   logic [7:0] sta_n = 8'hFF, ost_n = 8'hFF, rx_byte = 8'h00, tx_byte;
   logic src_n = 1'b0, mode_n = 1'b1, pol_n = 1'b1, link_err = 1'b0, rclk, rload, rdata;
   logic cfg_v, rate_bad, rx_valid = 1'b0, rx_first = 1'b0, rx_last = 1'b0;
   logic tx_valid, tx_first, tx_last, tx_ready = 1'b0, seen, sender_ok;
   logic [5:0] sta_addr, ost_addr, rx_sender = 6'h00, tx_dest;
   logic [15:0] ser_n = 16'hFFFF;
   int fails = 0, n_tests = 0;
   assign hready = hreadyout;
   srq_top #(.PRODUCT_ID(PID), .VERSION_TENS(8'h30), .VERSION_ONES(8'h31)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .station_switch_input_n(sta_n), .output_station_switch_input_n(ost_n),
      .setting_source_select_n(src_n), .setting_mode_select_n(mode_n),
      .analog_polarity_select_n(pol_n), .converter_link_error(link_err),
      .reader_clock(rclk), .reader_load(rload), .reader_data(rdata),
      .config_valid(cfg_v), .sampling_method(method), .link_rate(rate),
      .link_rate_invalid(rate_bad), .station_address(sta_addr),
      .output_station_address(ost_addr), .rx_valid(rx_valid), .rx_first(rx_first),
      .rx_last(rx_last), .rx_byte(rx_byte), .rx_sender(rx_sender), .tx_valid(tx_valid),
      .tx_first(tx_first), .tx_last(tx_last), .tx_byte(tx_byte), .tx_dest(tx_dest),
      .tx_ready(tx_ready), .change_mail_seen(seen), .change_sender_ok(sender_ok));
   srq_reader_model u_reader (.reader_clock(rclk), .reader_load(rload),
      .switch_pins_n(ser_n), .reader_data(rdata));
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   ////////////////////////////////////////
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_for(ref logic s, input int lim);
      int k;
      k = 0;
      @(posedge hclk);
      while (s !== 1'b1 && k < lim)
      begin
         @(posedge hclk);
         k++;
      end
      if (s !== 1'b1)
      begin
         chk(s, 1'b1);
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      wait_for(hready, 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_for(hready, 50);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
      chk(hresp, 1'b0);
   endtask
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      wait_for(cfg_v, 4000);
   endtask
   task automatic set_pins(input logic [7:0] s, input logic [7:0] o);
      sta_n <= ~s;
      ost_n <= ~o;
      ser_n <= ~{o, s};
   endtask
   task automatic send(input logic [63:0] m, input logic [5:0] who);
      for (int i = 0; i < 8; i++)
      begin
         rx_valid <= 1'b1;
         rx_first <= (i == 0);
         rx_last <= (i == 7);
         rx_byte <= m[8*i +: 8];
         rx_sender <= who;
         @(posedge hclk);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
   endtask
   ////////////////////////////////////////
   task automatic t_decode();
      for (int i = 0; i < 4; i++)
      begin
         set_pins({i[1:0], 6'h2A}, {i[1:0], 6'h15});
         do_reset();
         chk(method, i[1:0]);
         chk(rate, i[1:0]);
         chk(rate_bad, i == 3);
         chk(sta_addr, 6'h2A);
         chk(ost_addr, 6'h15);
      end
   endtask
   task automatic t_hold();
      set_pins(8'h00, 8'h00);
      repeat (20) @(posedge hclk);
      rd(REG_SETTING, {10'h0, 4'hF, 2'b01, 16'hD5EA});
   endtask
   task automatic t_inquiry();
      int n, k;
      logic [7:0] ex [24];
      ex = '{8'h58, 8'h5A, 8'h30, 8'h30, 8'h5A, 8'h20, 8'h30, 8'h31, 8'h4D, 8'h00, 8'h45,
         8'h8C, 8'hB2, 8'h40, 8'h00, 8'h00, 8'h34, 8'h12, 8'h01, 8'h10, 8'hAB, 8'h01,
         8'h5C, 8'h00};
      set_pins(8'h45, 8'h8C);
      mode_n <= 1'b0;
      link_err <= 1'b1;
      do_reset();
      rd(REG_INTERVAL, 32'h000A);
      rd(REG_FUNCTION, 32'h03);
      rd(REG_COUNT, 32'h08);
      rd(REG_TRIG_ADDR, 32'h0);
      rd(REG_TRIG_DATA, 32'hFF);
      wr(8'h40, 32'hFFFF);
      rd(8'h40, 32'h0);
      wr(REG_INTERVAL, 32'h1234);
      wr(REG_FUNCTION, 32'h01);
      wr(REG_COUNT, 32'h10);
      wr(REG_TRIG_ADDR, 32'h01AB);
      wr(REG_TRIG_DATA, 32'h5C);
      send(64'h0D3F2074656E5543, 6'h21);
      n = 0;
      k = 0;
      while (n < 24 && k < 200)
      begin
         @(posedge hclk);
         k++;
         if (tx_valid === 1'b1 && tx_ready === 1'b1)
         begin
            chk(tx_byte, ex[n]);
            chk(tx_first, n == 0);
            chk(tx_last, n == 23);
            chk(tx_dest, 6'h21);
            n++;
         end
         tx_ready <= ~tx_ready;
      end
      chk(n, 24);
      @(posedge hclk);
      chk(tx_valid, 1'b0);
   endtask
   task automatic t_change();
      logic s, ok, v;
      for (int j = 0; j < 2; j++)
      begin
         send(64'h0D3F2074656E5557, (j == 0) ? 6'h0C : 6'h21);
         s = 1'b0;
         ok = 1'b0;
         v = 1'b0;
         repeat (6)
         begin
            @(posedge hclk);
            if (seen === 1'b1)
            begin
               s = 1'b1;
               ok = sender_ok;
            end
            if (tx_valid !== 1'b0)
               v = 1'b1;
         end
         chk(s, 1'b1);
         chk(ok, j == 0);
         chk(v, 1'b0);
      end
   endtask
   task automatic t_serial();
      logic [31:0] r;
      src_n <= 1'b1;
      pol_n <= 1'b0;
      link_err <= 1'b0;
      ser_n <= ~16'h9A47;
      do_reset();
      rd(REG_SETTING, {10'h0, 2'b10, 2'b01, 2'b11, 16'h9A47});
      chk(sta_addr, 6'h07);
      bus(1'b0, REG_STATUS, 32'h0, r);
      chk(r[7:0], 8'hAB);
   endtask
   ////////////////////////////////////////
   initial
   begin
      @(posedge hclk);
      t_decode();
      t_hold();
      t_inquiry();
      t_change();
      t_serial();
      tally_and_finish();
   end
endmodule
